//--- src/drsr_map.vh
`ifndef DRSR_MAP_VH
`define DRSR_MAP_VH
// ==========================================
// Mode register addresses
`define DRSR_ADDR_BANK_MASK        8'h10
`define DRSR_ADDR_SEG_MASK         8'h11
`define DRSR_MASK_RESET            8'h00
// ==========================================
// Command encodings (cs_n low, ca[3:0], or ca[2:0] for self refresh, at rising link edge)
`define DRSR_CA_SELF_REFRESH       3'h4
`define DRSR_CA_REFRESH_ALL_BANK   4'hC
`define DRSR_CA_REFRESH_PER_BANK   4'h4
`define DRSR_CA_MRW                4'h0
`define DRSR_BANKS                 4
// ==========================================
// Timing, 200 MHz system clock
`define DRSR_CLK_PERIOD_PS         5000
`define DRSR_MIN_SR_RESIDENCY_NS   15
`define DRSR_MIN_SR_RESIDENCY_CYC  ((`DRSR_MIN_SR_RESIDENCY_NS * 1000 + `DRSR_CLK_PERIOD_PS - 1) / `DRSR_CLK_PERIOD_PS)
`define DRSR_SR_REFRESH_CYC        (`DRSR_MIN_SR_RESIDENCY_CYC - 1)
`endif

//--- src/drsr_sync3.v
`default_nettype none
// ==========================================
// Three-stage pin synchroniser; change taken when stages two and three agree
module drsr_sync3 #(
	parameter W = 1
) (
	input  wire         sys_clk,
	input  wire         arst_n,
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1   <= {W{1'b0}};
			stage2   <= {W{1'b0}};
			stage3   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				sync_out <= stage3;
		end
	end
endmodule // drsr_sync3
`default_nettype wire

//--- src/drsr_refresh_ctl.v
// Rules of the document; this block implements only those tagged in the code below
// [R01] Controller refreshes minimum count per window
// [R02] Eight per-bank refreshes replace one all-bank
// [R03] At most eight all-bank refreshes per burst window
// [R04] Self-refresh time reduces required refresh count
// [R05] Other banks stay usable during per-bank refresh
// [R06] Per-bank counter starts at bank zero
// [R07] All-bank refresh clears per-bank counter
// [R08] Self-refresh entry: cke low, cs low, ca=100
// [R09] Cke high before entry, nop after
// [R10] Cke held low to stay in self refresh
// [R11] In self refresh only cke is heard
// [R12] Internal all-bank refresh within residency time
// [R13] Controller respects minimum self-refresh residency
// [R14] Clock may stop; two stable cycles before exit (exit here follows cke alone, link clock not checked)
// [R15] Nops during exit delay, cke held high
// [R16] One refresh after exit before next entry
// [R17] All banks idle before self-refresh entry
// [R18] Eight-bit bank mask written by mode write
// [R19] Masked bank not refreshed in self refresh
// [R20] Segment mask unused below 1Gb
// [R21] Region refreshed only when both bits clear
// [R22] Only bank mask bits 0 to 3 used
`default_nettype none
`include "drsr_map.vh"
module drsr_refresh_ctl (
	input  wire       sys_clk,
	input  wire       arst_n,
	input  wire       link_ck,
	input  wire       cke,
	input  wire       cs_n,
	input  wire [9:0] ca,
	output reg        in_self_refresh,
	output reg        sr_refresh_pulse,
	output reg  [3:0] sr_refresh_banks,
	output reg        all_bank_refresh_pulse,
	output reg        per_bank_refresh_pulse,
	output reg  [1:0] per_bank_target,
	output reg  [3:0] bank_busy,
	output reg  [7:0] bank_refresh_mask,
	output reg  [7:0] segment_refresh_mask
);
	// ==========================================
	// Pin sampling
	wire [12:0] pins_s;
	drsr_sync3 #(.W(13)) u_sync (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.pin_in   ({link_ck, cke, cs_n, ca}),
		.sync_out (pins_s)
	);
	wire       ck_s   = pins_s[12];
	wire       cke_s  = pins_s[11];
	wire       cs_n_s = pins_s[10];
	wire [9:0] ca_s   = pins_s[9:0];
	reg        ck_d;
	reg        cke_d;
	reg        mrw_half;
	reg  [7:0] mrw_addr;
	wire [7:0] mrw_full;
	reg  [7:0] resid_cnt;
	reg  [7:0] busy_cnt;
	// Full-width copy so the 8-bit counters take a deliberate slice
	wire [31:0] sr_ref_cyc = `DRSR_SR_REFRESH_CYC;
	wire       ck_rise = ck_s & ~ck_d;
	wire       cmd     = ck_rise & ~cs_n_s & cke_s;
	// Cke as seen at the previous link rise, not the previous system cycle
	wire       enter   = ck_rise & ~cs_n_s & cke_d & ~cke_s
	                   & (ca_s[2:0] == `DRSR_CA_SELF_REFRESH); // [R08]
	// Low address bits arrive on the falling half
	assign mrw_full = {mrw_addr[7:2], ca_s[1:0]};
	// Bank decode used by busy logic
	function [3:0] drsr_onehot;
		input [1:0] b;
		begin
			drsr_onehot = 4'h1 << b;
		end
	endfunction
	// ==========================================
	// Command decode
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ck_d                   <= 1'b0;
			cke_d                  <= 1'b0;
			in_self_refresh        <= 1'b0;
			sr_refresh_pulse       <= 1'b0;
			sr_refresh_banks       <= 4'h0;
			all_bank_refresh_pulse <= 1'b0;
			per_bank_refresh_pulse <= 1'b0;
			per_bank_target        <= 2'h0;
			bank_busy              <= 4'h0;
			bank_refresh_mask      <= `DRSR_MASK_RESET;
			segment_refresh_mask   <= `DRSR_MASK_RESET;
			mrw_half               <= 1'b0;
			mrw_addr               <= 8'h00;
			resid_cnt              <= 8'h00;
			busy_cnt               <= 8'h00;
		end else begin
			ck_d                   <= ck_s;
			if (ck_rise)
				cke_d <= cke_s;
			sr_refresh_pulse       <= 1'b0;
			all_bank_refresh_pulse <= 1'b0;
			per_bank_refresh_pulse <= 1'b0;
			if (busy_cnt != 8'h00)
				busy_cnt <= busy_cnt - 8'h01;
			else
				bank_busy <= 4'h0;
			if (in_self_refresh) begin
				// Only cke heard; clock may be stopped, residency timed locally
				if (resid_cnt != 8'hFF)
					resid_cnt <= resid_cnt + 8'h01; // [R11] [R14]
				if (resid_cnt == sr_ref_cyc[7:0]) begin
					sr_refresh_pulse <= 1'b1; // [R12]
					// Masked banks left unrefreshed; segments n/a at 512Mb
					sr_refresh_banks <= ~bank_refresh_mask[3:0]; // [R19] [R20] [R21] [R22]
				end
				if (cke_s)
					in_self_refresh <= 1'b0; // [R10]
			end else if (enter) begin
				in_self_refresh <= 1'b1;
				resid_cnt       <= 8'h00;
				mrw_half        <= 1'b0;
			end else if (mrw_half && ck_s && !ck_d) begin
				mrw_half <= 1'b0;
			end else if (mrw_half && !ck_s && ck_d) begin
				// Falling half carries data on ca[9:2]
				mrw_half <= 1'b0;
				if (mrw_full == `DRSR_ADDR_BANK_MASK)
					bank_refresh_mask <= ca_s[9:2]; // [R18]
				else if (mrw_full == `DRSR_ADDR_SEG_MASK)
					segment_refresh_mask <= ca_s[9:2];
			end else if (cmd) begin
				if (ca_s[3:0] == `DRSR_CA_REFRESH_ALL_BANK) begin
					all_bank_refresh_pulse <= 1'b1;
					per_bank_target        <= 2'h0; // [R06] [R07]
				end else if (ca_s[3:0] == `DRSR_CA_REFRESH_PER_BANK) begin
					per_bank_refresh_pulse <= 1'b1;
					// Only the target bank goes busy
					bank_busy       <= drsr_onehot(per_bank_target); // [R05]
					busy_cnt        <= sr_ref_cyc[7:0];
					per_bank_target <= per_bank_target + 2'h1;
				end else if (ca_s[3:0] == `DRSR_CA_MRW) begin
					mrw_half <= 1'b1;
					mrw_addr <= {ca_s[9:4], 2'b00};
				end
			end
		end
	end
endmodule // drsr_refresh_ctl
`default_nettype wire

//--- verif/drsr_props.sv
`default_nettype none
`include "drsr_map.vh"
module drsr_props (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic       cke,
	input wire logic       in_self_refresh,
	input wire logic       sr_refresh_pulse,
	input wire logic [3:0] sr_refresh_banks,
	input wire logic       all_bank_refresh_pulse,
	input wire logic       per_bank_refresh_pulse,
	input wire logic [1:0] per_bank_target,
	input wire logic [3:0] bank_busy,
	input wire logic [7:0] bank_refresh_mask
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SR_MAX = `DRSR_MIN_SR_RESIDENCY_CYC;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ====
	// Self refresh, all-bank target clear, per-bank busy
	sequence sr_entry; $rose(in_self_refresh); endsequence
	sequence sr_internal; sr_refresh_pulse && in_self_refresh; endsequence
	sr_timer_a: assert property (sr_entry |-> ##[1:SR_MAX] sr_internal)
		else $error("sr timer");
	sr_banks_a: assert property (sr_refresh_pulse |->
		sr_refresh_banks == ~bank_refresh_mask[3:0]) else $error("sr banks");
	sr_deaf_a: assert property (in_self_refresh |->
		!all_bank_refresh_pulse && !per_bank_refresh_pulse) else $error("sr deaf");
	sr_hold_a: assert property (in_self_refresh && !cke |=> in_self_refresh)
		else $error("sr hold");
	mask_keep_a: assert property (in_self_refresh |=> $stable(bank_refresh_mask))
		else $error("mask held");
	ab_clear_a: assert property (all_bank_refresh_pulse |->
		##[0:1] per_bank_target == 2'h0) else $error("target clear");
	pb_busy_a: assert property (per_bank_refresh_pulse |-> ##[0:1] $onehot(bank_busy))
		else $error("bank busy");
	busy_one_a: assert property ($onehot0(bank_busy)) else $error("busy one");
endmodule // drsr_props
`default_nettype wire

//--- verif/drsr_ctl_model.sv
`default_nettype none
module drsr_ctl_model (
	input  wire logic       sys_clk,
	output var  logic       link_ck,
	output var  logic       cke,
	output var  logic       cs_n,
	output var  logic [9:0] ca
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {link_ck, cke, cs_n, ca} = 13'h0C00;
	// Link clock stands low outside a command; idle CA inverted so stale data never matches
	task automatic cyc(input logic k, s, input logic [9:0] r, f);
		cke <= k;
		cs_n <= s;
		ca <= r;
		repeat (2) @(posedge sys_clk);
		link_ck <= 1'b1;
		repeat (3) @(posedge sys_clk);
		ca <= f;
		repeat (3) @(posedge sys_clk);
		link_ck <= 1'b0;
		repeat (6) @(posedge sys_clk);
		cs_n <= 1'b1;
		ca <= ~f;
		@(posedge sys_clk);
	endtask
endmodule // drsr_ctl_model
`default_nettype wire

//--- verif/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic link_ck, cke, cs_n;
	logic [9:0] ca;
	logic in_self_refresh, sr_refresh_pulse, all_bank_refresh_pulse, per_bank_refresh_pulse;
	logic [3:0] sr_refresh_banks, bank_busy;
	logic [1:0] per_bank_target;
	logic [7:0] bank_refresh_mask, segment_refresh_mask, n_ab = 8'h00, n_sr = 8'h00;
	int n_fail = 0;
	int samples_checked = 0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) n_ab <= n_ab + {7'h00, all_bank_refresh_pulse};
	always @(posedge sys_clk) n_sr <= n_sr + {7'h00, sr_refresh_pulse};
	drsr_ctl_model mc (.sys_clk, .link_ck, .cke, .cs_n, .ca);
	drsr_refresh_ctl uut (.sys_clk, .arst_n, .link_ck, .cke, .cs_n, .ca, .in_self_refresh,
		.sr_refresh_pulse, .sr_refresh_banks, .all_bank_refresh_pulse, .per_bank_refresh_pulse,
		.per_bank_target, .bank_busy, .bank_refresh_mask, .segment_refresh_mask);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_regs();
		chk(bank_refresh_mask, 8'h00);
		chk({6'h00, per_bank_target}, 8'h00);
		mc.cyc(1'b1, 1'b0, 10'h040, {8'hF5, 2'h0});
		mc.cyc(1'b1, 1'b0, 10'h040, {8'h3C, 2'h1});
		chk(bank_refresh_mask, 8'hF5);
		chk(segment_refresh_mask, 8'h3C);
		$display("regs done");
	endtask
	task automatic t_ref();
		mc.cyc(1'b1, 1'b0, 10'h004, 10'h000);
		mc.cyc(1'b1, 1'b0, 10'h004, 10'h000);
		chk({6'h00, per_bank_target}, 8'h02);
		mc.cyc(1'b1, 1'b0, 10'h00C, 10'h000);
		chk({6'h00, per_bank_target}, 8'h00);
		chk(n_ab, 8'h01);
		$display("ref done");
	endtask
	task automatic t_sr();
		mc.cyc(1'b1, 1'b1, 10'h3FF, 10'h3FF);
		mc.cyc(1'b0, 1'b0, 10'h004, 10'h000);
		mc.cyc(1'b0, 1'b1, 10'h3FF, 10'h3FF);
		mc.cyc(1'b0, 1'b0, 10'h00C, 10'h000);
		chk({7'h00, in_self_refresh}, 8'h01);
		chk(n_ab, 8'h01);
		chk({7'h00, n_sr != 8'h00}, 8'h01);
		mc.cyc(1'b1, 1'b1, 10'h000, 10'h000);
		for (int i = 0; i < 99 && in_self_refresh !== 1'b0; i++)
			@(posedge sys_clk);
		chk({7'h00, in_self_refresh}, 8'h00);
		if (in_self_refresh !== 1'b0)
			test_done();
		mc.cyc(1'b1, 1'b0, 10'h00C, 10'h000);
		chk(n_ab, 8'h02);
		$display("sr done");
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_regs();
		t_ref();
		t_sr();
		test_done();
	end
endmodule // testbench
bind drsr_refresh_ctl drsr_props chk_i (.sys_clk, .arst_n, .cke, .in_self_refresh,
	.sr_refresh_pulse, .sr_refresh_banks, .all_bank_refresh_pulse, .per_bank_refresh_pulse,
	.per_bank_target, .bank_busy, .bank_refresh_mask);
`default_nettype wire
